// ===== design/asp_pkg.sv
// Functional notes
// - First channel starts 0..255 bit clocks after the framing edge; reset 0.
// - Port config bit 1 releases the line, bit 0 enables hold latch; both reset 0.
// - Standard stereo: each MSB valid on second bit-clock rise after word-clock edge.
// - DSP: word-clock rise starts frame, left then right, bits valid on falls.
// - DSP time-slot: right sample placed 0..255 bit clocks after left ends.
// - Right-justified: each LSB valid on the rise just before the word-clock edge.
// - Left-justified: each MSB valid on the rise following the word-clock edge.
// - Mono PCM: word-clock rise starts one sample per frame, bits valid on falls.
// - TDM: drive shared output only inside own sub-frame, release it otherwise.
// - Modes 3, 4, 5 take a double-data-rate density stream on serial input.
// - Density master drives bit-clock pin at eight times sample rate.
// - Modes 3 and 5 return current on rising phase, voltage on falling phase.
// - Single density input channel; config bit 2 picks rising or falling phase.
// - Density config bit 1 selects slave input clock or master output clock.
// - Three-bit format field: standard, DSP, RJ, LJ, mono PCM, DSP time-slot.
// - Two-bit width field: 16, 20, 24, 32 bits MSB first; reset 24.
// - Enabled hold latch keeps last output level while the line is released and port config bit 1 is set.
package asp_pkg;

  localparam int ASP_AW = 8;

  // Register byte offsets
  localparam logic [7:0] ADDR_FIRST_DELAY = 8'h00;
  localparam logic [7:0] ADDR_PORT_CFG    = 8'h04;
  localparam logic [7:0] ADDR_GAP         = 8'h08;
  localparam logic [7:0] ADDR_DENSITY_CFG = 8'h0C;
  localparam logic [7:0] ADDR_FORMAT      = 8'h10;
  localparam logic [7:0] ADDR_OP_MODE     = 8'h14;
  localparam logic [7:0] ADDR_TX_LEFT     = 8'h18;
  localparam logic [7:0] ADDR_TX_RIGHT    = 8'h1C;
  localparam logic [7:0] ADDR_RX_LEFT     = 8'h20;
  localparam logic [7:0] ADDR_RX_RIGHT    = 8'h24;
  localparam logic [7:0] ADDR_DENSITY_RX  = 8'h28;
  localparam logic [7:0] ADDR_STATUS      = 8'h2C;

  // Field positions
  localparam int PCFG_RELEASE_BIT = 1;
  localparam int PCFG_HOLD_BIT    = 0;
  localparam int DCFG_EDGE_BIT    = 2;
  localparam int DCFG_CIN_BIT     = 1;
  localparam int DCFG_COUT_BIT    = 0;
  localparam int FMT_SEL_MSB      = 4;
  localparam int FMT_SEL_LSB      = 2;
  localparam int WIDTH_MSB        = 1;
  localparam int WIDTH_LSB        = 0;
  localparam int MODE_MSB         = 3;
  localparam int HTRANS_ACT_BIT   = 1;

  // Reset values
  localparam logic [7:0]  RST_DELAY   = 8'h00;
  localparam logic [7:0]  RST_GAP     = 8'h00;
  localparam logic [2:0]  RST_FORMAT  = 3'h0;
  localparam logic [1:0]  RST_WIDTH   = 2'h2;
  localparam logic [3:0]  RST_OP_MODE = 4'h1;
  localparam logic        HRESP_OKAY  = 1'b0;

  // Operating modes
  localparam logic [3:0] MODE_PCM_SENSE    = 4'h2;
  localparam logic [3:0] MODE_PCM_DENSITY  = 4'h3;
  localparam logic [3:0] MODE_DENSITY_ONLY = 4'h4;
  localparam logic [3:0] MODE_DENSITY_BOTH = 4'h5;

  // Framing
  localparam logic [9:0] I2S_LEAD = 10'h001;
  localparam logic [9:0] CNT_MAX  = 10'h3FF;

  // Density clock timing
  localparam longint HCLK_HZ        = 100000000;
  localparam longint FS_HZ          = 48000;
  localparam longint DENSITY_RATIO  = 8;
  localparam int DENSITY_HALF_CYCLES =
    int'(HCLK_HZ / (2 * DENSITY_RATIO * FS_HZ));

  typedef enum logic [2:0] {
    FMT_STANDARD   = 3'b000,
    FMT_DSP        = 3'b001,
    FMT_RIGHT_JUST = 3'b010,
    FMT_LEFT_JUST  = 3'b011,
    FMT_MONO_PCM   = 3'b100,
    FMT_DSP_SLOT   = 3'b101
  } asp_format_t;

  typedef struct packed {
    logic [7:0] first_slot_delay;
    logic [7:0] second_channel_gap;
    logic       output_release_enable;
    logic       hold_latch_enable;
    logic       density_input_edge_select;
    logic       density_input_clock_direction;
    logic       density_output_clock_direction;
    logic [2:0] frame_format_select;
    logic [1:0] sample_width_select;
    logic [3:0] op_mode;
  } asp_cfg_t;

  typedef struct packed {
    logic       hit;
    logic       right;
    logic [5:0] idx;
    logic       last;
  } asp_slot_t;

  function automatic logic [5:0] asp_width_bits(input logic [1:0] code);
    unique case (code)
      2'b00: asp_width_bits = 6'h10;
      2'b01: asp_width_bits = 6'h14;
      2'b10: asp_width_bits = 6'h18;
      2'b11: asp_width_bits = 6'h20;
    endcase
  endfunction : asp_width_bits

endpackage : asp_pkg

// ===== design/asp_sync.sv
`timescale 1ns/100ps
module asp_sync
  import asp_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  // Pins and settled levels
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_level;

  // A change counts once the second and third stages agree
  always_comb begin
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2[i] == s3[i]) begin
        next_level[i] = s3[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      level <= '0;
    end else if (clk_en) begin
      s1    <= pin_async;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end

endmodule : asp_sync

// ===== design/asp_div.sv
`timescale 1ns/100ps
module asp_div
  import asp_pkg::*;
#(
  parameter int HALF = DENSITY_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clk_en,
  // Control and generated clock
  input  wire logic run,
  output logic      clk_out,
  output logic      rise,
  output logic      fall
);

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_clk;
  logic        next_rise;
  logic        next_fall;

  always_comb begin
    next_cnt  = cnt;
    next_clk  = clk_out;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (!run) begin
      next_cnt = '0;
      next_clk = 1'b0;
    end else if (cnt == 16'(HALF - 1)) begin
      next_cnt  = '0;
      next_clk  = ~clk_out;
      next_rise = ~clk_out;
      next_fall = clk_out;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt     <= '0;
      clk_out <= 1'b0;
      rise    <= 1'b0;
      fall    <= 1'b0;
    end else if (clk_en) begin
      cnt     <= next_cnt;
      clk_out <= next_clk;
      rise    <= next_rise;
      fall    <= next_fall;
    end
  end

endmodule : asp_div

// ===== design/asp_port.sv
`timescale 1ns/100ps
module asp_port
  import asp_pkg::*;
#(
  parameter int DENSITY_HALF = DENSITY_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial pins
  input  wire logic        bclk_in,
  output logic             bclk_out,
  output logic             bclk_oe,
  input  wire logic        wclk_in,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  output logic             keeper_en,
  // Sense streams
  input  wire logic        sense_current,
  input  wire logic        sense_voltage
);

  asp_cfg_t    cfg;
  asp_cfg_t    next_cfg;
  logic [31:0] tx_left;
  logic [31:0] tx_right;
  logic [31:0] next_tx_left;
  logic [31:0] next_tx_right;
  logic        ap_valid;
  logic        ap_write;
  logic [7:0]  ap_addr;
  logic        next_ap_valid;
  logic [7:0]  next_ap_addr;
  logic [31:0] next_hrdata;

  logic [2:0]  pin_lvl;
  logic        bclk_lvl;
  logic        wclk_lvl;
  logic        din_lvl;
  logic        div_rise;
  logic        div_fall;

  logic        bclk_last;
  logic        wclk_prev;
  logic [9:0]  cnt;
  logic [9:0]  half_len;
  logic        chan_right;
  logic [31:0] rx_shift;
  logic [31:0] rx_left;
  logic [31:0] rx_right;
  logic [31:0] density_rx;
  logic        next_bclk_last;
  logic        next_wclk_prev;
  logic [9:0]  next_cnt;
  logic [9:0]  next_half;
  logic        next_right;
  logic [31:0] next_rx_shift;
  logic [31:0] next_rx_left;
  logic [31:0] next_rx_right;
  logic [31:0] next_density_rx;
  logic        next_dout;
  logic        next_dout_oe;
  logic        next_keeper;
  logic        next_bclk_oe;

  logic        density;
  logic        pdm_master;
  logic        pcm_out;
  logic        pdm_out;
  logic        ck_rise;
  logic        ck_fall;
  logic        dsp;
  asp_slot_t   rise_slot;
  asp_slot_t   fall_slot;
  asp_slot_t   drv;
  asp_slot_t   cap;
  logic        drv_ev;
  logic        cap_ev;
  logic [31:0] word;
  logic [31:0] shifted;
  logic [5:0]  wbits;

  function automatic logic is_dsp(input logic [2:0] f);
    is_dsp = (f == FMT_DSP) || (f == FMT_DSP_SLOT) || (f == FMT_MONO_PCM);
  endfunction : is_dsp

  // Finds the channel and bit index that a frame position falls in
  function automatic asp_slot_t slot_find(input logic [9:0] pos,
                                          input asp_cfg_t   c,
                                          input logic [9:0] hlen,
                                          input logic       rhalf);
    asp_slot_t  s;
    logic [9:0] w;
    logic [9:0] sl;
    logic [9:0] sr;
    logic       r_ok;
    s    = '0;
    w    = {4'h0, asp_width_bits(c.sample_width_select)};
    sl   = {2'b00, c.first_slot_delay};
    sr   = sl + w;
    r_ok = 1'b0;
    unique case (c.frame_format_select)
      FMT_STANDARD:   sl = sl + I2S_LEAD;
      FMT_RIGHT_JUST: sl = hlen - w + sl;
      FMT_LEFT_JUST:  sl = sl;
      FMT_DSP:        r_ok = 1'b1;
      FMT_DSP_SLOT: begin
        sr   = sr + {2'b00, c.second_channel_gap};
        r_ok = 1'b1;
      end
      FMT_MONO_PCM:   r_ok = 1'b0;
      default:        sl = sl;
    endcase
    if (pos >= sl && (pos - sl) < w) begin
      s.hit   = 1'b1;
      s.right = is_dsp(c.frame_format_select) ? 1'b0 : rhalf;
      s.idx   = 6'(pos - sl);
    end else if (r_ok && pos >= sr && (pos - sr) < w) begin
      s.hit   = 1'b1;
      s.right = 1'b1;
      s.idx   = 6'(pos - sr);
    end
    s.last = s.hit && (s.idx == 6'(w - 10'h001));
    return s;
  endfunction : slot_find

  asp_sync #(
    .WIDTH     (3)
  ) u_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .pin_async ({bclk_in, wclk_in, din}),
    .level     (pin_lvl)
  );

  assign bclk_lvl = pin_lvl[2];
  assign wclk_lvl = pin_lvl[1];
  assign din_lvl  = pin_lvl[0];

  asp_div #(
    .HALF    (DENSITY_HALF)
  ) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .run     (pdm_master),
    .clk_out (bclk_out),
    .rise    (div_rise),
    .fall    (div_fall)
  );

  // Register file over AHB-Lite, zero wait states
  always_comb begin
    next_cfg      = cfg;
    next_tx_left  = tx_left;
    next_tx_right = tx_right;
    next_ap_valid = hsel && htrans[HTRANS_ACT_BIT] && hready;
    next_ap_addr  = haddr[ASP_AW-1:0];
    next_hrdata   = hrdata;
    if (ap_valid && ap_write) begin
      unique case (ap_addr)
        ADDR_FIRST_DELAY: next_cfg.first_slot_delay = hwdata[7:0];
        ADDR_GAP:         next_cfg.second_channel_gap = hwdata[7:0];
        ADDR_PORT_CFG: begin
          next_cfg.output_release_enable = hwdata[PCFG_RELEASE_BIT];
          next_cfg.hold_latch_enable     = hwdata[PCFG_HOLD_BIT];
        end
        ADDR_DENSITY_CFG: begin
          next_cfg.density_input_edge_select = hwdata[DCFG_EDGE_BIT];
          next_cfg.density_input_clock_direction = hwdata[DCFG_CIN_BIT];
          next_cfg.density_output_clock_direction = hwdata[DCFG_COUT_BIT];
        end
        ADDR_FORMAT: begin
          next_cfg.frame_format_select = hwdata[FMT_SEL_MSB:FMT_SEL_LSB];
          next_cfg.sample_width_select = hwdata[WIDTH_MSB:WIDTH_LSB];
        end
        ADDR_OP_MODE:  next_cfg.op_mode = hwdata[MODE_MSB:0];
        ADDR_TX_LEFT:  next_tx_left = hwdata;
        ADDR_TX_RIGHT: next_tx_right = hwdata;
        default:       next_cfg = cfg;
      endcase
    end
    if (next_ap_valid && !hwrite) begin
      unique case (next_ap_addr)
        ADDR_FIRST_DELAY: next_hrdata = {24'h0, next_cfg.first_slot_delay};
        ADDR_GAP:         next_hrdata = {24'h0, next_cfg.second_channel_gap};
        ADDR_PORT_CFG:    next_hrdata = {30'h0,
                                         next_cfg.output_release_enable,
                                         next_cfg.hold_latch_enable};
        ADDR_DENSITY_CFG: next_hrdata = {29'h0,
                                 next_cfg.density_input_edge_select,
                                 next_cfg.density_input_clock_direction,
                                 next_cfg.density_output_clock_direction};
        ADDR_FORMAT:      next_hrdata = {27'h0, next_cfg.frame_format_select,
                                         next_cfg.sample_width_select};
        ADDR_OP_MODE:     next_hrdata = {28'h0, next_cfg.op_mode};
        ADDR_TX_LEFT:     next_hrdata = next_tx_left;
        ADDR_TX_RIGHT:    next_hrdata = next_tx_right;
        ADDR_RX_LEFT:     next_hrdata = rx_left;
        ADDR_RX_RIGHT:    next_hrdata = rx_right;
        ADDR_DENSITY_RX:  next_hrdata = density_rx;
        ADDR_STATUS:      next_hrdata = {18'h0, half_len, 1'b0, dout_oe,
                                         density, chan_right};
        default:          next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg                                <= '0;
      cfg.first_slot_delay               <= RST_DELAY;
      cfg.second_channel_gap             <= RST_GAP;
      cfg.frame_format_select            <= RST_FORMAT;
      cfg.sample_width_select            <= RST_WIDTH;
      cfg.op_mode                        <= RST_OP_MODE;
      tx_left                            <= '0;
      tx_right                           <= '0;
      ap_valid                           <= 1'b0;
      ap_write                           <= 1'b0;
      ap_addr                            <= '0;
      hrdata                             <= '0;
      hreadyout                          <= 1'b1;
      hresp                              <= HRESP_OKAY;
    end else if (clk_en) begin
      cfg       <= next_cfg;
      tx_left   <= next_tx_left;
      tx_right  <= next_tx_right;
      ap_valid  <= next_ap_valid;
      ap_write  <= hwrite;
      ap_addr   <= next_ap_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // Serial framing, density stream and output line control
  always_comb begin
    density = (cfg.op_mode == MODE_PCM_DENSITY) ||
              (cfg.op_mode == MODE_DENSITY_ONLY) ||
              (cfg.op_mode == MODE_DENSITY_BOTH);
    pdm_out = (cfg.op_mode == MODE_PCM_DENSITY) ||
              (cfg.op_mode == MODE_DENSITY_BOTH);
    pcm_out = (cfg.op_mode == MODE_PCM_SENSE);
    pdm_master = density && cfg.density_input_clock_direction;
    ck_rise = pdm_master ? div_rise : (bclk_lvl && !bclk_last);
    ck_fall = pdm_master ? div_fall : (!bclk_lvl && bclk_last);
    dsp     = is_dsp(cfg.frame_format_select);
    wbits   = asp_width_bits(cfg.sample_width_select);
    next_bclk_last  = bclk_lvl;
    next_bclk_oe    = pdm_master;
    next_wclk_prev  = wclk_prev;
    next_cnt        = cnt;
    next_half       = half_len;
    next_right      = chan_right;
    next_rx_shift   = rx_shift;
    next_rx_left    = rx_left;
    next_rx_right   = rx_right;
    next_density_rx = density_rx;
    next_dout       = dout;
    next_dout_oe    = dout_oe;
    if (!density && ck_rise) begin
      next_wclk_prev = wclk_lvl;
      if (dsp ? (wclk_lvl && !wclk_prev) : (wclk_lvl != wclk_prev)) begin
        next_cnt  = '0;
        next_half = cnt + 10'h001;
        if (!dsp) begin
          next_right = (cfg.frame_format_select == FMT_STANDARD) ?
                       wclk_lvl : !wclk_lvl;
        end
      end else if (cnt != CNT_MAX) begin
        next_cnt = cnt + 10'h001;
      end
    end
    rise_slot = slot_find(next_cnt, cfg, next_half, next_right);
    if (!dsp && wclk_lvl != wclk_prev) begin
      fall_slot = slot_find(10'h000, cfg, cnt + 10'h001,
                            (cfg.frame_format_select == FMT_STANDARD) ?
                            wclk_lvl : !wclk_lvl);
    end else begin
      fall_slot = slot_find(dsp ? cnt : cnt + 10'h001, cfg, half_len,
                            chan_right);
    end
    drv     = dsp ? rise_slot : fall_slot;
    cap     = dsp ? fall_slot : rise_slot;
    drv_ev  = dsp ? ck_rise : ck_fall;
    cap_ev  = dsp ? ck_fall : ck_rise;
    word    = drv.right ? tx_right : tx_left;
    shifted = {rx_shift[30:0], din_lvl};
    if (!density) begin
      if (drv_ev) begin
        if (drv.hit && pcm_out) begin
          next_dout = word[5'(wbits - 6'h01 - drv.idx)];
        end
        next_dout_oe = pcm_out &&
                       (drv.hit || !cfg.output_release_enable);
      end
      if (cap_ev && cap.hit) begin
        next_rx_shift = shifted;
        if (cap.last) begin
          if (cap.right) begin
            next_rx_right = shifted & 32'((64'h1 << wbits) - 64'h1);
          end else begin
            next_rx_left = shifted & 32'((64'h1 << wbits) - 64'h1);
          end
        end
      end
      if (!pcm_out) begin
        next_dout_oe = 1'b0;
      end
    end else begin
      if (ck_rise) begin
        next_dout = pdm_out ? sense_current : dout;
        if (!cfg.density_input_edge_select) begin
          next_density_rx = {density_rx[30:0], din_lvl};
        end
      end
      if (ck_fall) begin
        next_dout = pdm_out ? sense_voltage : dout;
        if (cfg.density_input_edge_select) begin
          next_density_rx = {density_rx[30:0], din_lvl};
        end
      end
      next_dout_oe = pdm_out;
    end
    next_keeper = cfg.hold_latch_enable && cfg.output_release_enable &&
                  !next_dout_oe;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bclk_last  <= 1'b0;
      bclk_oe    <= 1'b0;
      wclk_prev  <= 1'b0;
      cnt        <= '0;
      half_len   <= '0;
      chan_right <= 1'b0;
      rx_shift   <= '0;
      rx_left    <= '0;
      rx_right   <= '0;
      density_rx <= '0;
      dout       <= 1'b0;
      dout_oe    <= 1'b0;
      keeper_en  <= 1'b0;
    end else if (clk_en) begin
      bclk_last  <= next_bclk_last;
      bclk_oe    <= next_bclk_oe;
      wclk_prev  <= next_wclk_prev;
      cnt        <= next_cnt;
      half_len   <= next_half;
      chan_right <= next_right;
      rx_shift   <= next_rx_shift;
      rx_left    <= next_rx_left;
      rx_right   <= next_rx_right;
      density_rx <= next_density_rx;
      dout       <= next_dout;
      dout_oe    <= next_dout_oe;
      keeper_en  <= next_keeper;
    end
  end

endmodule : asp_port

// ===== tb/asp_port_asserts.sv
`timescale 1ns/100ps
module asp_port_asserts
  import asp_pkg::*;
#(
  parameter int DENSITY_HALF = 8
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Pins
  input wire logic        bclk_out,
  input wire logic        bclk_oe,
  input wire logic        dout,
  input wire logic        dout_oe,
  input wire logic        keeper_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !clk_en);
  logic rd_take;
  assign rd_take = hsel && htrans[1] && !hwrite && hready;
  // Seven quiet cycles: count follows DENSITY_HALF of 8
  sequence s_half;
    $stable(bclk_out) [*7] ##1 $changed(bclk_out);
  endsequence
  sequence s_quiet;
    !dout_oe && !bclk_oe && !keeper_en && hrdata == 32'h0;
  endsequence
  a_bus_ready: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("hresp not okay");
  a_read_hold: assert property (!rd_take |=> $stable(hrdata))
    else $error("hrdata moved without a read");
  a_keep_release: assert property (keeper_en |-> !dout_oe)
    else $error("keeper on while driving");
  a_line_held: assert property (
    !dout_oe && !$past(dout_oe) |-> $stable(dout))
    else $error("released line moved");
  a_reset_quiet: assert property ($rose(hresetn) |-> s_quiet)
    else $error("outputs active after reset");
  a_freeze_all: assert property (disable iff (!hresetn)
    !clk_en |=> $stable({dout, dout_oe, keeper_en, bclk_out, hrdata}))
    else $error("state moved while frozen");
  a_density_half: assert property (
    bclk_oe && $changed(bclk_out) |=> s_half)
    else $error("density clock half period wrong");
endmodule : asp_port_asserts

bind asp_port asp_port_asserts #(.DENSITY_HALF(DENSITY_HALF)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .bclk_out(bclk_out),
  .bclk_oe(bclk_oe), .dout(dout), .dout_oe(dout_oe),
  .keeper_en(keeper_en));

// ===== tb/asp_host.sv
`timescale 1ns/100ps
module asp_host (
  // Toward the device
  output logic      bclk_in,
  output logic      wclk_in,
  output logic      din,
  // From the device
  input  wire logic bclk_out,
  input  wire logic bclk_oe,
  input  wire logic dout,
  input  wire logic dout_oe
);
  logic bclk_drv;
  // Pin level: device clock while it drives, else ours
  assign bclk_in = bclk_oe ? bclk_out : bclk_drv;
  initial begin
    bclk_drv = 1'b0;
    wclk_in = 1'b1;
    din = 1'b0;
  end
  // Word clock low half then high half, sampled at each fall
  task automatic frame(input int half, output logic [63:0] bits,
                       output logic [63:0] oes);
    #3.7;
    for (int h = 0; h < 2; h++) begin
      wclk_in = h[0];
      for (int i = 0; i < half; i++) begin
        #40 bclk_drv = 1'b1;
        #40 bclk_drv = 1'b0;
        bits[h * 32 + i] = dout;
        oes[h * 32 + i] = dout_oe;
        din = 1'($urandom_range(1, 0));
      end
    end
  endtask : frame
endmodule : asp_host

// ===== tb/tb_asp_port.sv
`timescale 1ns/100ps
module tb_asp_port;
  import asp_pkg::*;
  logic        hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout;
  logic        hresp, bclk_in, bclk_out, bclk_oe, wclk_in, din, dout;
  logic        dout_oe, keeper_en, sense_current, sense_voltage;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          num_errors = 0;
  int          samples_checked = 0;
  assign hready = hreadyout;
  asp_port #(.DENSITY_HALF(8)) DUT (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bclk_in(bclk_in),
    .bclk_out(bclk_out), .bclk_oe(bclk_oe), .wclk_in(wclk_in),
    .din(din), .dout(dout), .dout_oe(dout_oe), .keeper_en(keeper_en),
    .sense_current(sense_current), .sense_voltage(sense_voltage));
  asp_host host (.bclk_in(bclk_in), .wclk_in(wclk_in), .din(din),
    .bclk_out(bclk_out), .bclk_oe(bclk_oe), .dout(dout),
    .dout_oe(dout_oe));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  function automatic logic in_slot(input int p, input int d);
    return p > d && p <= d + 16;
  endfunction : in_slot
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    logic [7:0]  ra [6] = '{ADDR_FIRST_DELAY, ADDR_PORT_CFG, ADDR_GAP,
                            ADDR_DENSITY_CFG, ADDR_FORMAT, 8'h30};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0};
    logic [31:0] mk [6] = '{32'hFF, 32'h3, 32'hFF, 32'h7, 32'h1F, 32'h0};
    logic [31:0] rd, tl, tr;
    logic [63:0] b, o;
    int          d, p, lj;
    void'($urandom(32'h6C1B4022));
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sense_current = 1'b0;
    sense_voltage = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int j = 0; j < 6; j++) begin
      bus(1'b0, ra[j], 32'h0, rd);
      chk(rd, rv[j]);
      tl = (j == 0) ? 32'hFFFFFFFF : $urandom;
      bus(1'b1, ra[j], tl, rd);
      bus(1'b0, ra[j], 32'h0, rd);
      chk(rd, tl & mk[j]);
    end
    $display("test registers done");
    bus(1'b1, ADDR_FORMAT, 32'h0, rd);
    bus(1'b1, ADDR_OP_MODE, 32'h2, rd);
    for (int rel = 0; rel < 4; rel++) begin
      lj = rel / 2;
      d = (rel % 2) ? $urandom_range(14, 1) : 0;
      tl = $urandom;
      tr = $urandom;
      bus(1'b1, ADDR_FIRST_DELAY, 32'(d), rd);
      bus(1'b1, ADDR_PORT_CFG, (rel % 2) ? 32'h3 : 32'h0, rd);
      bus(1'b1, ADDR_FORMAT, {27'h0, lj ? FMT_LEFT_JUST : FMT_STANDARD,
                              2'b00}, rd);
      bus(1'b1, ADDR_TX_LEFT, tl, rd);
      bus(1'b1, ADDR_TX_RIGHT, tr, rd);
      host.frame(32, b, o);
      host.frame(32, b, o);
      for (int i = 0; i < 64; i++) begin
        p = i % 32;
        if (in_slot(p, d - lj)) begin
          chk(b[i], ((i < 32) != lj) ? tl[16 + d - lj - p] :
                                       tr[16 + d - lj - p]);
          chk(o[i], 1'b1);
        end else begin
          chk(o[i], rel % 2 == 0);
        end
      end
      chk(keeper_en, rel % 2);
      $display("test frame %0d done", rel);
    end
    clk_en <= 1'b0;
    repeat (5) @(posedge hclk);
    clk_en <= 1'b1;
    bus(1'b1, ADDR_DENSITY_CFG, 32'h0, rd);
    bus(1'b1, ADDR_OP_MODE, {28'h0, MODE_PCM_DENSITY}, rd);
    host.frame(4, b, o);
    chk(bclk_oe, 1'b0);
    for (int i = 0; i < 8; i++) begin
      chk(o[i % 4 + 32 * (i / 4)], 1'b1);
    end
    bus(1'b1, ADDR_DENSITY_CFG, 32'h2, rd);
    repeat (20) @(posedge hclk);
    chk(bclk_oe, 1'b1);
    for (int k = 0; k < 6; k++) begin
      sense_current <= 1'($urandom_range(1, 0));
      sense_voltage <= 1'($urandom_range(1, 0));
      repeat (2) @(posedge bclk_out);
      @(negedge bclk_out);
      chk(dout, sense_current);
      @(posedge bclk_out);
      chk(dout, sense_voltage);
    end
    $display("test density done");
    summarize();
  end
endmodule : tb_asp_port
